// File: flash_mode_pkg.sv
// constants and types for the serial flash operating-state control
package flash_mode_pkg;
    localparam logic [7:0] OP_RST_EN   = 8'h66;
    localparam logic [7:0] OP_RST      = 8'h99;
    localparam logic [7:0] OP_SUSPEND  = 8'h75;
    localparam logic [7:0] OP_RESUME   = 8'h7a;
    localparam logic [7:0] OP_SLEEP    = 8'hb9;
    localparam logic [7:0] OP_RELEASE  = 8'hab;
    localparam logic [7:0] OP_QUAD_ON  = 8'h38;
    localparam logic [7:0] OP_QUAD_OFF = 8'hff;
    localparam logic [7:0] OP_WEN      = 8'h06;
    localparam logic [7:0] OP_WSR1     = 8'h01;
    localparam logic [7:0] OP_WSR2     = 8'h11;
    localparam logic [7:0] OP_SEC_ER   = 8'h44;
    localparam logic [7:0] OP_SEC_PG   = 8'h42;
    localparam logic [7:0] OP_SE       = 8'h20;
    localparam logic [7:0] OP_BE32     = 8'h52;
    localparam logic [7:0] OP_BE64     = 8'hd8;
    localparam logic [7:0] OP_CE1      = 8'hc7;
    localparam logic [7:0] OP_CE2      = 8'h60;
    localparam logic [7:0] OP_PP       = 8'h02;
    localparam logic [7:0] OP_QPP      = 8'h32;
    localparam logic [7:0] OP_RPARAM   = 8'hc0;
    localparam logic [7:0] OP_WRAP     = 8'h77;
    localparam logic [7:0] DEV_ID      = 8'h5a; // arbitrary value
    localparam int CLK_NS        = 10;
    localparam int RESUME_NS     = 200;
    localparam int RESUME_CYC    = RESUME_NS / CLK_NS;
    localparam int SUS_NS        = 1000;
    localparam int SUS_CYC       = SUS_NS / CLK_NS;
    localparam int SLEEP_NS      = 500;
    localparam int SLEEP_CYC     = (SLEEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_NS        = 1000;
    localparam int RST_CYC       = (RST_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] RESUME_CNT = 16'(RESUME_CYC);
    localparam logic [15:0] SUS_CNT    = 16'(SUS_CYC);
    localparam logic [15:0] SLEEP_CNT  = 16'(SLEEP_CYC);
    localparam logic [15:0] RST_CNT    = 16'(RST_CYC);
    localparam logic [5:0]  ID_START   = 6'h20;
    localparam logic [5:0]  BITS_OP_SER = 6'h08;
    localparam logic [5:0]  BITS_OP_QW  = 6'h02;
    localparam logic [5:0]  ID_DUMMY_SER = 6'h18;
    localparam logic [5:0]  ID_DUMMY_QW  = 6'h06;
    localparam logic [3:0]  ID_OE        = 4'h2;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_PROG    = 5'h02,
        ST_ERASE   = 5'h04,
        ST_SUSP    = 5'h08,
        ST_RESET   = 5'h10
    } op_state_t;

    typedef struct packed {
        logic busy_flag;
        logic sus_prog;
        logic sus_erase;
        logic write_latch_flag;
        logic four_wire_command_mode;
        logic deep_sleep;
    } status_t;
endpackage : flash_mode_pkg

// File: edge_sync.sv
// two-stage synchroniser with edge detection of the synchronised level
`timescale 1ns/100ps
`default_nettype none
module edge_sync #(
    parameter logic IDLE = 1'b0
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_t;
    sync_t st_q;
    sync_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = din;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            // reset to the pin's idle level so no false edge follows reset
            st_q <= {3{IDLE}};
        end else begin
            st_q <= st_d;
        end
    end

    assign level = st_q.s2;
    assign rise  = st_q.s2 & ~st_q.s3;
    assign fall  = ~st_q.s2 & st_q.s3;
endmodule : edge_sync
`default_nettype wire

// File: flash_mode_ctrl.sv
// operating-state control of the serial flash: opcode decode, suspend, sleep, reset
`timescale 1ns/100ps
`default_nettype none
module flash_mode_ctrl (
    input  wire logic                   ref_clk,
    input  wire logic                   nrst,
    input  wire logic                   cs_n,
    input  wire logic                   sclk,
    input  wire logic [3:0]             io_in,
    input  wire logic                   quad_enable_flag,
    input  wire logic                   start_prog,
    input  wire logic                   start_erase,
    input  wire logic                   op_done,
    output logic [3:0]                  io_out,
    output logic [3:0]                  io_oe,
    output logic                        busy_flag,
    output logic [1:0]                  suspended_flags,
    output logic                        write_latch_flag,
    output logic                        four_wire_command_mode,
    output logic                        deep_sleep,
    output logic                        reject_pulse,
    output logic [7:0]                  read_param_bits,
    output logic [7:0]                  continuous_read_bits,
    output logic [2:0]                  wrap_bits
);
    logic rst_s1_q;
    logic rst_s2_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    logic cs_lvl, cs_rise, cs_fall;
    logic ck_rise, ck_fall;
    logic [3:0] io_s1_q;
    logic [3:0] io_s2_q;

    edge_sync #(.IDLE(1'b1)) u_cs (
        .ref_clk (ref_clk),
        .rst_n   (rst_s2_q),
        .din     (cs_n),
        .level   (cs_lvl),
        .rise    (cs_rise),
        .fall    (cs_fall)
    );
    edge_sync u_ck (
        .ref_clk (ref_clk),
        .rst_n   (rst_s2_q),
        .din     (sclk),
        .level   (),
        .rise    (ck_rise),
        .fall    (ck_fall)
    );

    // io sampled with the same latency as the clock edge detector
    always_ff @(posedge ref_clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            io_s1_q <= '0;
            io_s2_q <= '0;
        end else begin
            io_s1_q <= io_in;
            io_s2_q <= io_s1_q;
        end
    end

    typedef struct packed {
        flash_mode_pkg::op_state_t op;
        flash_mode_pkg::op_state_t sus_from;
        flash_mode_pkg::status_t   st;
        logic [7:0]                sh;
        logic [5:0]                nbits;
        logic                      op_done_flag;
        logic [7:0]                opcode;
        logic                      rst_armed;
        logic                      id_mode;
        logic [2:0]                id_bit;
        logic                      sleep_pend;
        logic [15:0]               cnt;
        logic                      sus_pend;
        logic                      res_pend;
        logic [7:0]                rparam;
        logic [7:0]                cread;
        logic [2:0]                wrap;
        logic                      rej;
        logic [3:0]                out;
        logic [3:0]                oe;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic   busy;
    logic   frame_ok;
    logic [5:0] op_len;
    logic [7:0] op_next;

    always_comb begin
        s_d     = s_q;
        s_d.rej = 1'b0;
        busy    = s_q.st.busy_flag;
        op_len  = s_q.st.four_wire_command_mode ? flash_mode_pkg::BITS_OP_QW
                                                : flash_mode_pkg::BITS_OP_SER;
        op_next = s_q.st.four_wire_command_mode ? {s_q.sh[3:0], io_s2_q}
                                                : {s_q.sh[6:0], io_s2_q[0]};
        // opcode shifts in during the frame, decoded at frame end
        if (cs_fall) begin
            s_d.nbits        = '0;
            s_d.op_done_flag = 1'b0;
            s_d.id_mode      = 1'b0;
            s_d.id_bit       = '0;
        end
        if (!cs_lvl && ck_rise && s_q.op != flash_mode_pkg::ST_RESET) begin
            if (!s_q.op_done_flag) begin
                s_d.sh = op_next;
                if (s_q.nbits + 6'd1 == op_len) begin
                    s_d.op_done_flag = 1'b1;
                    s_d.opcode       = op_next;
                    s_d.nbits        = '0;
                end else begin
                    s_d.nbits = s_q.nbits + 6'd1;
                end
            end else begin
                s_d.nbits = s_q.nbits + 6'd1;
                // three dummy bytes after release start the id stream
                if (s_q.opcode == flash_mode_pkg::OP_RELEASE && !busy
                    && s_q.nbits + 6'd1 == (s_q.st.four_wire_command_mode
                       ? flash_mode_pkg::ID_DUMMY_QW : flash_mode_pkg::ID_DUMMY_SER)) begin
                    s_d.id_mode = 1'b1;
                end
            end
        end
        if (!cs_lvl && ck_fall && s_q.id_mode) begin
            s_d.out[1] = flash_mode_pkg::DEV_ID[3'd7 - s_q.id_bit];
            s_d.oe     = flash_mode_pkg::ID_OE;
            s_d.id_bit = s_q.id_bit + 3'd1;
        end
        if (cs_rise) begin
            s_d.oe      = '0;
            s_d.id_mode = 1'b0;
        end
        // frame end: decode only complete opcodes
        if (cs_rise && s_q.op_done_flag && s_q.op != flash_mode_pkg::ST_RESET) begin
            s_d.rst_armed = 1'b0;
            if (s_q.st.deep_sleep) begin
                // only release and reset pass in sleep
                if (s_q.opcode == flash_mode_pkg::OP_RELEASE) begin
                    s_d.st.deep_sleep = 1'b0;
                end else if (s_q.opcode == flash_mode_pkg::OP_RST_EN) begin
                    s_d.rst_armed = 1'b1;
                end else if (s_q.opcode == flash_mode_pkg::OP_RST && s_q.rst_armed) begin
                    s_d.op  = flash_mode_pkg::ST_RESET;
                    s_d.cnt = flash_mode_pkg::RST_CNT;
                end else begin
                    s_d.rej = 1'b1;
                end
            end else begin
                case (s_q.opcode)
                    flash_mode_pkg::OP_RST_EN: s_d.rst_armed = 1'b1;
                    flash_mode_pkg::OP_RST: begin
                        if (s_q.rst_armed && s_q.nbits == '0) begin
                            s_d.op  = flash_mode_pkg::ST_RESET;
                            s_d.cnt = flash_mode_pkg::RST_CNT;
                        end
                    end
                    flash_mode_pkg::OP_SUSPEND: begin
                        if ((s_q.op == flash_mode_pkg::ST_PROG
                             || s_q.op == flash_mode_pkg::ST_ERASE)
                            && busy && !s_q.st.sus_prog && !s_q.st.sus_erase) begin
                            s_d.sus_from = s_q.op;
                            s_d.st.sus_prog  = s_q.op == flash_mode_pkg::ST_PROG;
                            s_d.st.sus_erase = s_q.op == flash_mode_pkg::ST_ERASE;
                            s_d.sus_pend = 1'b1;
                            s_d.cnt      = flash_mode_pkg::SUS_CNT;
                        end else begin
                            s_d.rej = 1'b1;
                        end
                    end
                    flash_mode_pkg::OP_RESUME: begin
                        if ((s_q.st.sus_prog || s_q.st.sus_erase) && !busy) begin
                            s_d.st.sus_prog  = 1'b0;
                            s_d.st.sus_erase = 1'b0;
                            s_d.res_pend = 1'b1;
                            s_d.cnt      = flash_mode_pkg::RESUME_CNT;
                        end else begin
                            s_d.rej = 1'b1;
                        end
                    end
                    flash_mode_pkg::OP_SLEEP: begin
                        if (!busy && s_q.nbits == '0) begin
                            s_d.sleep_pend = 1'b1;
                            s_d.cnt        = flash_mode_pkg::SLEEP_CNT;
                        end else begin
                            s_d.rej = 1'b1;
                        end
                    end
                    flash_mode_pkg::OP_RELEASE: s_d.rej = busy;
                    flash_mode_pkg::OP_QUAD_ON: begin
                        if (quad_enable_flag) begin
                            s_d.st.four_wire_command_mode = 1'b1;
                        end else begin
                            s_d.rej = 1'b1;
                        end
                    end
                    flash_mode_pkg::OP_QUAD_OFF: s_d.st.four_wire_command_mode = 1'b0;
                    flash_mode_pkg::OP_WEN: s_d.st.write_latch_flag = !busy;
                    flash_mode_pkg::OP_WSR1, flash_mode_pkg::OP_WSR2,
                    flash_mode_pkg::OP_SEC_ER, flash_mode_pkg::OP_SE,
                    flash_mode_pkg::OP_BE32, flash_mode_pkg::OP_BE64,
                    flash_mode_pkg::OP_CE1, flash_mode_pkg::OP_CE2: begin
                        if (s_q.st.sus_prog || s_q.st.sus_erase) begin
                            s_d.rej = 1'b1;
                        end
                    end
                    flash_mode_pkg::OP_SEC_PG, flash_mode_pkg::OP_PP,
                    flash_mode_pkg::OP_QPP: begin
                        if (s_q.st.sus_prog) begin
                            s_d.rej = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
        // array cycles start from outside only when allowed
        if (s_q.op == flash_mode_pkg::ST_IDLE && !s_q.st.deep_sleep && !cs_rise
            && !(start_erase && (s_q.st.sus_prog || s_q.st.sus_erase))
            && !(start_prog && s_q.st.sus_prog)) begin
            if (start_prog || start_erase) begin
                s_d.op           = start_prog ? flash_mode_pkg::ST_PROG
                                              : flash_mode_pkg::ST_ERASE;
                s_d.st.busy_flag = 1'b1;
            end
        end
        if ((s_q.op == flash_mode_pkg::ST_PROG || s_q.op == flash_mode_pkg::ST_ERASE)
            && op_done && !s_q.sus_pend) begin
            s_d.op                  = (s_q.st.sus_prog || s_q.st.sus_erase)
                                      ? flash_mode_pkg::ST_SUSP : flash_mode_pkg::ST_IDLE;
            s_d.st.busy_flag        = 1'b0;
            s_d.st.write_latch_flag = 1'b0;
        end
        // timed actions
        if (s_q.sus_pend || s_q.res_pend || s_q.sleep_pend || s_q.op == flash_mode_pkg::ST_RESET) begin
            if (s_q.cnt <= 16'h0001) begin
                if (s_q.sus_pend) begin
                    s_d.sus_pend     = 1'b0;
                    s_d.st.busy_flag = 1'b0;
                    s_d.op           = flash_mode_pkg::ST_SUSP;
                end
                if (s_q.res_pend) begin
                    s_d.res_pend     = 1'b0;
                    s_d.st.busy_flag = 1'b1;
                    s_d.op           = s_q.sus_from;
                end
                if (s_q.sleep_pend) begin
                    s_d.sleep_pend    = 1'b0;
                    s_d.st.deep_sleep = 1'b1;
                end
                if (s_q.op == flash_mode_pkg::ST_RESET) begin
                    s_d.op = flash_mode_pkg::ST_IDLE;
                end
            end else begin
                s_d.cnt = s_q.cnt - 16'h0001;
            end
        end
        if (s_d.op == flash_mode_pkg::ST_RESET && s_q.op != flash_mode_pkg::ST_RESET) begin
            // abort and return to power-on values
            s_d.st         = '0;
            s_d.sus_pend   = 1'b0;
            s_d.res_pend   = 1'b0;
            s_d.sleep_pend = 1'b0;
            s_d.rparam     = '0;
            s_d.cread      = '0;
            s_d.wrap       = '0;
            s_d.rst_armed  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            s_q          <= '0;
            s_q.op       <= flash_mode_pkg::ST_IDLE;
            s_q.sus_from <= flash_mode_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign io_out                 = s_q.out;
    assign io_oe                  = s_q.oe;
    assign busy_flag              = s_q.st.busy_flag;
    assign suspended_flags        = {s_q.st.sus_erase, s_q.st.sus_prog};
    assign write_latch_flag       = s_q.st.write_latch_flag;
    assign four_wire_command_mode = s_q.st.four_wire_command_mode;
    assign deep_sleep             = s_q.st.deep_sleep;
    assign reject_pulse           = s_q.rej;
    assign read_param_bits        = s_q.rparam;
    assign continuous_read_bits   = s_q.cread;
    assign wrap_bits              = s_q.wrap;

    sequence sus_accept_s;
        cs_rise && s_q.op_done_flag && !s_q.st.deep_sleep
        && s_q.opcode == flash_mode_pkg::OP_SUSPEND && s_q.op == flash_mode_pkg::ST_PROG
        && busy_flag && suspended_flags == 2'b00;
    endsequence

    sus_flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_s2_q)
        sus_accept_s |=> suspended_flags == 2'b01)
        else $error("suspend flag not set after suspend");
    sus_busy_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_s2_q)
        sus_accept_s |-> ##[1:101] !busy_flag)
        else $error("busy not cleared within suspend latency");
    res_busy_set_a: assert property (@(posedge ref_clk) disable iff (!rst_s2_q)
        $fell(|suspended_flags) && !busy_flag && s_q.op != flash_mode_pkg::ST_RESET
        |-> ##[1:21] busy_flag)
        else $error("busy not set within resume time");
    sleep_busy_a: assert property (@(posedge ref_clk) disable iff (!rst_s2_q)
        $rose(deep_sleep) |-> !busy_flag)
        else $error("deep sleep entered while busy");
    quad_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_s2_q)
        $rose(four_wire_command_mode) |-> $past(quad_enable_flag))
        else $error("four-wire mode entered without quad enable");
    reset_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_s2_q)
        $rose(s_q.op == flash_mode_pkg::ST_RESET) |-> !write_latch_flag && !deep_sleep
        && suspended_flags == 2'b00 && !busy_flag && wrap_bits == 3'h0)
        else $error("volatile state not cleared by reset");
    mode_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_s2_q)
        $changed(four_wire_command_mode) && s_q.op != flash_mode_pkg::ST_RESET
        |-> $stable(write_latch_flag) && $stable(suspended_flags) && $stable(wrap_bits))
        else $error("mode switch changed latch, suspend or wrap");
    sleep_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_s2_q)
        $fell(deep_sleep) |-> $past(s_q.opcode) == flash_mode_pkg::OP_RELEASE
        || s_q.op == flash_mode_pkg::ST_RESET)
        else $error("deep sleep left by a wrong opcode");
    erase_block_a: assert property (@(posedge ref_clk) disable iff (!rst_s2_q)
        $rose(s_q.op == flash_mode_pkg::ST_ERASE) |-> !$past(s_q.st.sus_erase)
        || $past(s_q.res_pend))
        else $error("erase started while suspended");
endmodule : flash_mode_ctrl
`default_nettype wire

// File: flash_host_model.sv
// host controller model: frames opcodes onto chip select, serial clock and data pins
`timescale 1ns/100ps
`default_nettype none
module flash_host_model (
    input  wire logic       ref_clk,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe,
    output logic            cs_n,
    output logic            sclk,
    output logic [3:0]      io_in
);
    // last eight bits seen on the id line; a released line reads inverted
    logic [7:0] rx;
    initial begin
        cs_n  = 1'b1;
        sclk  = 1'b0;
        io_in = 4'h0;
    end
    // one frame: nclk clocks, msb first, high nibble first in four-wire mode
    task automatic frame(input logic [7:0] op, input int nclk, input logic quad);
        logic [7:0] sh;
        sh = op;
        @(posedge ref_clk) cs_n <= 1'b0;
        repeat (nclk) begin
            io_in <= quad ? sh[7:4] : {~io_in[3:1], sh[7]};
            sh = quad ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
            repeat (4) @(posedge ref_clk);
            sclk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            rx = {rx[6:0], io_oe[1] ? io_out[1] : ~io_out[1]};
            sclk <= 1'b0;
        end
        @(posedge ref_clk) cs_n <= 1'b1;
        io_in <= ~io_in;
        repeat (12) @(posedge ref_clk);
    endtask : frame
endmodule : flash_host_model
`default_nettype wire

// File: tb_serial_flash_mode_control.sv
// self-checking bench for the flash operating-state control
`timescale 1ns/100ps
`default_nettype none
module tb_serial_flash_mode_control;
    logic ref_clk, nrst, qe, sp, se, od, rej, busy, wl, qm, ds;
    logic [1:0] sus;
    logic [3:0] io_in, io_out, io_oe;
    logic [7:0] rp, cr;
    logic [2:0] wb;
    logic cs_n, sclk;
    int fails, total_checks, rej_cnt;
    flash_host_model host (.ref_clk(ref_clk), .io_out(io_out), .io_oe(io_oe), .cs_n(cs_n),
        .sclk(sclk), .io_in(io_in));
    flash_mode_ctrl uut (.ref_clk(ref_clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk),
        .io_in(io_in), .quad_enable_flag(qe), .start_prog(sp), .start_erase(se),
        .op_done(od), .io_out(io_out), .io_oe(io_oe), .busy_flag(busy),
        .suspended_flags(sus), .write_latch_flag(wl), .four_wire_command_mode(qm),
        .deep_sleep(ds), .reject_pulse(rej), .read_param_bits(rp), .continuous_read_bits(cr),
        .wrap_bits(wb));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (rej === 1'b1) rej_cnt++;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    // one-cycle pulse on {start_prog, start_erase, op_done}
    task automatic pulse(input logic [2:0] m);
        @(posedge ref_clk) {sp, se, od} <= m;
        @(posedge ref_clk) {sp, se, od} <= 3'h0;
        cyc(3);
    endtask : pulse
    task automatic t_suspend();
        int r;
        pulse(3'h4);
        chk("busy", busy, 1);
        host.frame(8'hb9, 8, 0);
        cyc(50);
        chk("sleep", ds, 0);
        host.frame(8'hab, 32, 0);
        chk("busy", busy, 1);
        host.frame(8'h75, 8, 0);
        chk("sus", sus, 2'b01);
        cyc(100);
        chk("busy", busy, 0);
        r = rej_cnt;
        host.frame(8'h02, 8, 0);
        chk("rej", rej_cnt, r + 1);
        host.frame(8'h75, 8, 0);
        chk("sus", sus, 2'b01);
        host.frame(8'h7a, 8, 0);
        chk("sus", sus, 0);
        cyc(20);
        chk("busy", busy, 1);
        pulse(3'h1);
        chk("busy", busy, 0);
        host.frame(8'h75, 8, 0);
        chk("sus", sus, 0);
        $display("suspend test done");
    endtask : t_suspend
    task automatic t_sleep();
        int r;
        host.frame(8'hb9, 4, 0);
        cyc(50);
        chk("sleep", ds, 0);
        host.frame(8'hb9, 8, 0);
        cyc(50);
        chk("sleep", ds, 1);
        r = rej_cnt;
        host.frame(8'h06, 8, 0);
        chk("latch", wl, 0);
        chk("rej", rej_cnt, r + 1);
        host.frame(8'hab, 8, 0);
        chk("sleep", ds, 0);
        host.frame(8'hab, 48, 0);
        chk("id", host.rx, flash_mode_pkg::DEV_ID);
        chk("oe", io_oe, 0);
        $display("sleep test done");
    endtask : t_sleep
    task automatic t_mode();
        host.frame(8'h38, 8, 0);
        chk("mode", qm, 0);
        qe <= 1'b1;
        host.frame(8'h06, 8, 0);
        host.frame(8'h38, 8, 0);
        chk("mode", qm, 1);
        chk("latch", wl, 1);
        host.frame(8'hff, 2, 1);
        chk("mode", qm, 0);
        chk("latch", wl, 1);
        host.frame(8'h38, 8, 0);
        chk("mode", qm, 1);
        host.frame(8'h66, 2, 1);
        host.frame(8'h99, 2, 1);
        cyc(100);
        chk("mode", qm, 0);
        chk("latch", wl, 0);
        chk("param", rp, 0);
        chk("cread", cr, 0);
        chk("wrap", wb, 0);
        pulse(3'h2);
        host.frame(8'h75, 8, 0);
        chk("sus", sus, 2'b10);
        host.frame(8'h66, 8, 0);
        host.frame(8'h99, 8, 0);
        cyc(100);
        chk("sus", sus, 0);
        chk("busy", busy, 0);
        $display("mode test done");
    endtask : t_mode
    task automatic t_power_up();
        chk("sleep", ds, 0);
        chk("busy", busy, 0);
        chk("oe", io_oe, 0);
        chk("wrap", wb, 0);
        $display("power-up test done");
    endtask : t_power_up
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    initial begin
        #300000;
        fails++;
        end_sim();
    end
    initial begin
        {nrst, qe, sp, se, od} = 5'h00;
        cyc(10);
        nrst <= 1'b1;
        cyc(6);
        t_power_up();
        t_suspend();
        t_sleep();
        t_mode();
        end_sim();
    end
endmodule : tb_serial_flash_mode_control
`default_nettype wire
